// file: src/ifb_top.sv
// Frame buffer control with ring buffer and retransmit store.
module ifb_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ifb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ifb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ifb_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [ifb_pkg::CFG_W-1:0] img_cfg,
  input wire logic cap_valid,
  input wire logic [ifb_pkg::IMG_W-1:0] cap_data,
  input wire logic acq_continuous,
  input wire logic stream_en,
  input wire logic one_shot,
  input wire logic multi_shot,
  input wire logic [ifb_pkg::CNT_W-1:0] shot_count,
  output logic tx_valid,
  output logic [ifb_pkg::IMG_W-1:0] tx_data,
  output logic tx_buffered
);
  localparam int PW = ifb_pkg::PTR_W;
  localparam int CW = ifb_pkg::CNT_W;

  ifb_pkg::ifb_state_t st_q, st_d;
  logic buf_on_q, sel_q;
  logic [CW-1:0] cap_q, cnt_q, cnt_d, remain_q, remain_d;
  logic [PW-1:0] wr_q, rd_q, wr_d, rd_d;
  logic [ifb_pkg::CFG_W-1:0] cfg_q;
  logic [ifb_pkg::IMG_W-1:0] mem_q [ifb_pkg::DEPTH];
  logic [ifb_pkg::IMG_W-1:0] retx_q, tx_data_d;
  logic [ifb_pkg::DATA_W-1:0] reg_rdata_d;

  function automatic logic [PW-1:0] ptr_inc(
    input logic [PW-1:0] p,
    input logic [PW-1:0] last
  );
    ptr_inc = (p == last) ? '0 : p + 3'h1;
  endfunction : ptr_inc

  // Register decode
  wire hit = (reg_addr == ifb_pkg::REG_CTRL);
  wire wr_ctrl = reg_wr && hit;
  wire cfg_chg = (img_cfg != cfg_q);
  wire init_wr = wr_ctrl && reg_wdata[ifb_pkg::BIT_BUF_ON];
  wire buf_init = cfg_chg || init_wr;
  wire [CW-1:0] cap_new =
    ifb_pkg::cap_lookup(img_cfg[ifb_pkg::COLOR_MSB:ifb_pkg::COLOR_LSB]);
  wire [ifb_pkg::DATA_W-1:0] ctrl_word =
    {buf_on_q, sel_q, ifb_pkg::RSV_ZERO, cap_q, cnt_q};
  assign reg_rdata_d = (reg_rd && hit) ? ctrl_word : '0;

  // Source and request decode
  wire src_buf = sel_q && !acq_continuous;
  wire idle = (st_q == ifb_pkg::ST_IDLE);
  wire req_ok = idle && !acq_continuous;
  wire start_one = req_ok && one_shot;
  wire start_multi = req_ok && !one_shot && multi_shot &&
    (shot_count != ifb_pkg::CNT_ZERO);
  wire full = (cnt_q == cap_q);
  wire empty = (cnt_q == ifb_pkg::CNT_ZERO);
  wire push = cap_valid && buf_on_q;
  wire send_live = cap_valid &&
    ((idle && acq_continuous) || st_q == ifb_pkg::ST_LIVE);
  wire send_one = (st_q == ifb_pkg::ST_ONE) && !acq_continuous;
  wire send_buf = (st_q == ifb_pkg::ST_BUFM) && !empty &&
    !acq_continuous;
  wire pop = send_buf;
  wire tx_valid_d = send_live || send_one || send_buf;
  wire tx_buf_d = send_one || send_buf;
  wire last_shot = (remain_q == ifb_pkg::CNT_ONE);
  wire [PW-1:0] cap_last = PW'(cap_q - ifb_pkg::CNT_ONE);
  assign tx_data_d = send_buf ? mem_q[rd_q] :
    (send_one ? retx_q : cap_data);

  // Transmit sequencing
  always_comb begin
    st_d = st_q;
    remain_d = remain_q;
    case (st_q)
      ifb_pkg::ST_IDLE: begin
        if (start_one) begin
          st_d = src_buf ? ifb_pkg::ST_ONE : ifb_pkg::ST_LIVE;
          remain_d = ifb_pkg::CNT_ONE;
        end else if (start_multi) begin
          st_d = src_buf ? ifb_pkg::ST_BUFM : ifb_pkg::ST_LIVE;
          remain_d = shot_count;
        end
      end
      ifb_pkg::ST_LIVE: begin
        if (cap_valid) begin
          remain_d = remain_q - ifb_pkg::CNT_ONE;
          if (last_shot) begin
            st_d = ifb_pkg::ST_IDLE;
          end
        end
      end
      ifb_pkg::ST_ONE: begin
        st_d = ifb_pkg::ST_IDLE;
      end
      ifb_pkg::ST_BUFM: begin
        if (empty || buf_init || acq_continuous) begin
          st_d = ifb_pkg::ST_IDLE;
        end else begin
          remain_d = remain_q - ifb_pkg::CNT_ONE;
          if (last_shot) begin
            st_d = ifb_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        st_d = ifb_pkg::ST_IDLE;
      end
    endcase
  end

  // Ring pointers and fill count
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (buf_init) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = ifb_pkg::CNT_ZERO;
    end else begin
      if (push) begin
        wr_d = ptr_inc(wr_q, cap_last);
      end
      if (pop || (push && full)) begin
        rd_d = ptr_inc(rd_q, cap_last);
      end
      if (push && !pop && !full) begin
        cnt_d = cnt_q + ifb_pkg::CNT_ONE;
      end else if (pop && !push) begin
        cnt_d = cnt_q - ifb_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= ifb_pkg::ST_IDLE;
      remain_q <= ifb_pkg::CNT_ZERO;
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= ifb_pkg::CNT_ZERO;
    end else begin
      st_q <= st_d;
      remain_q <= remain_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_q <= ifb_pkg::CFG_RST;
      cap_q <= ifb_pkg::CAP_RST;
    end else if (cfg_chg) begin
      cfg_q <= img_cfg;
      cap_q <= cap_new;
    end
  end

  // Control bits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buf_on_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (wr_ctrl) begin
      buf_on_q <= reg_wdata[ifb_pkg::BIT_BUF_ON];
      if (!stream_en) begin
        sel_q <= reg_wdata[ifb_pkg::BIT_SEL];
      end
    end
  end

  // Image storage
  always_ff @(posedge sys_clk) begin
    if (push && !buf_init) begin
      mem_q[wr_q] <= cap_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      retx_q <= ifb_pkg::IMG_RST;
      tx_valid <= 1'b0;
      tx_buffered <= 1'b0;
      tx_data <= ifb_pkg::IMG_RST;
      reg_rdata <= '0;
    end else begin
      if (tx_valid_d) begin
        retx_q <= tx_data_d;
      end
      tx_valid <= tx_valid_d;
      tx_buffered <= tx_buf_d;
      tx_data <= tx_data_d;
      reg_rdata <= reg_rdata_d;
    end
  end

  // Last image on the output
  logic [ifb_pkg::IMG_W-1:0] last_out_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_out_q <= ifb_pkg::IMG_RST;
    end else if (tx_valid) begin
      last_out_q <= tx_data;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_buf_not_cont: assert property (
    tx_valid && tx_buffered |-> !$past(acq_continuous))
    else $error("buffered image sent in continuous mode");
  a_one_start: assert property (
    start_one && sel_q |=> st_q == ifb_pkg::ST_ONE ##1 idle)
    else $error("one-shot did not start buffered send");
  a_multi_last: assert property (
    send_buf && last_shot && !buf_init
    |=> idle && tx_valid && tx_buffered)
    else $error("multi-shot did not end on last image");
  a_one_resend: assert property (
    send_one |=> tx_valid && tx_buffered && tx_data == $past(retx_q))
    else $error("one-shot did not resend stored image");
  a_live_single: assert property (
    start_one && !sel_q |=> st_q == ifb_pkg::ST_LIVE)
    else $error("one-shot did not arm single live frame");
  a_store_grow: assert property (
    push && !pop && !full && !buf_init |=> cnt_q == $past(cnt_q) + 12'h001)
    else $error("captured image not stored");
  a_full_wrap: assert property (
    push && full && !pop && !buf_init
    |=> cnt_q == $past(cnt_q) && rd_q == wr_q &&
      (rd_q != $past(rd_q) || cap_q == ifb_pkg::CNT_ONE))
    else $error("full buffer did not drop oldest image");
  a_retx_copy: assert property (
    send_one |=> tx_data == last_out_q)
    else $error("sent image not kept for resend");
  a_init_clear: assert property (
    init_wr |=> empty && wr_q == '0)
    else $error("buffer-on write did not empty buffer");
  a_cfg_init: assert property (
    cfg_chg |=> empty && cap_q == $past(cap_new))
    else $error("config change did not reset buffer");
  a_bufon_write: assert property (
    wr_ctrl |=> buf_on_q == $past(reg_wdata[ifb_pkg::BIT_BUF_ON]))
    else $error("buffer-on bit not written");
  a_sel_hold: assert property (
    wr_ctrl && stream_en |=> sel_q == $past(sel_q))
    else $error("source select changed while streaming");
  a_cap_nonzero: assert property (
    cap_q != ifb_pkg::CNT_ZERO)
    else $error("capacity reads zero");
  a_read_word: assert property (
    reg_rd && hit |=> reg_rdata[ifb_pkg::CNT_MSB:ifb_pkg::CNT_LSB]
      == $past(cnt_q) && reg_rdata[ifb_pkg::BIT_BUF_ON] == $past(buf_on_q))
    else $error("control word read mismatch");

  a_pop_shrink: assert property (
    pop && !push && !buf_init |=> cnt_q == $past(cnt_q) - ifb_pkg::CNT_ONE)
    else $error("sent buffered image not removed");
  a_off_no_store: assert property (
    cap_valid && !buf_on_q && !pop && !buf_init
    |=> cnt_q == $past(cnt_q))
    else $error("image stored while buffer off");
  a_count_bound: assert property (
    cnt_q <= cap_q)
    else $error("stored count above capacity");
  a_ring_align: assert property (
    (full || empty) |-> rd_q == wr_q)
    else $error("ring pointers out of step");
  a_cont_live: assert property (
    idle && acq_continuous && cap_valid
    |=> tx_valid && !tx_buffered && tx_data == $past(cap_data))
    else $error("continuous capture not sent live");
  a_live_pass: assert property (
    st_q == ifb_pkg::ST_LIVE && cap_valid
    |=> tx_valid && !tx_buffered && tx_data == $past(cap_data))
    else $error("armed live frame not sent");
  a_live_end: assert property (
    st_q == ifb_pkg::ST_LIVE && cap_valid && last_shot |=> idle)
    else $error("live frames did not stop at count");
  a_live_wait: assert property (
    st_q == ifb_pkg::ST_LIVE && !cap_valid
    |=> st_q == ifb_pkg::ST_LIVE && remain_q == $past(remain_q))
    else $error("live frame count moved without image");
  a_multi_start: assert property (
    start_multi && src_buf
    |=> st_q == ifb_pkg::ST_BUFM && remain_q == $past(shot_count))
    else $error("multi-shot did not start buffered send");
  a_multi_empty: assert property (
    st_q == ifb_pkg::ST_BUFM && empty |=> idle && !tx_valid)
    else $error("multi-shot did not stop on empty buffer");
  a_bufm_pop: assert property (
    send_buf
    |=> tx_valid && tx_buffered && tx_data == $past(mem_q[rd_q]))
    else $error("buffered image not sent oldest first");
  a_retx_hold: assert property (
    !tx_valid_d |=> retx_q == $past(retx_q))
    else $error("resend store changed without a send");
  a_sel_write: assert property (
    wr_ctrl && !stream_en |=> sel_q == $past(reg_wdata[ifb_pkg::BIT_SEL]))
    else $error("source select not written");
  a_ctrl_hold: assert property (
    !wr_ctrl
    |=> buf_on_q == $past(buf_on_q) && sel_q == $past(sel_q))
    else $error("control bits changed without a write");
  a_read_cap: assert property (
    reg_rd && hit
    |=> reg_rdata[ifb_pkg::CAP_MSB:ifb_pkg::CAP_LSB] == $past(cap_q))
    else $error("capacity field read mismatch");
  a_read_ctrl: assert property (
    reg_rd && hit |=> reg_rdata[ifb_pkg::BIT_SEL] == $past(sel_q) &&
      reg_rdata[ifb_pkg::BIT_SEL-1:ifb_pkg::CAP_MSB+1] == ifb_pkg::RSV_ZERO)
    else $error("select or reserved bits read mismatch");
  a_rdata_quiet: assert property (
    !(reg_rd && hit) |=> reg_rdata == '0)
    else $error("read data not quiet");
  a_cap_widest: assert property (
    cfg_chg && img_cfg[ifb_pkg::COLOR_MSB:ifb_pkg::COLOR_LSB] == 2'h0
    |=> cap_q == ifb_pkg::CAP_C0)
    else $error("capacity not reloaded for color code 0");
  a_cap_narrowest: assert property (
    cfg_chg && img_cfg[ifb_pkg::COLOR_MSB:ifb_pkg::COLOR_LSB] == 2'h3
    |=> cap_q == ifb_pkg::CAP_C3)
    else $error("capacity not reloaded for color code 3");
  a_cap_hold: assert property (
    !cfg_chg |=> cap_q == $past(cap_q))
    else $error("capacity changed without new format");

  c_multi_buf: cover property (start_multi && src_buf ##1 send_buf);
  c_overwrite: cover property (push && full && !pop);
  c_resend: cover property (send_one ##1 tx_valid);
  c_live_multi: cover property (start_multi && !src_buf ##[1:20] send_live);
  c_empty_stop: cover property (st_q == ifb_pkg::ST_BUFM && empty);
endmodule : ifb_top

// file: src/ifb_pkg.sv
// Constants, types and capacity lookup for the image frame buffer.
// Functional notes
// - Buffered images go out only while continuous acquisition is off.
// - With the source select at 1, one-shot or multi-shot sends buffered data.
// - Multi-shot sends as many buffered images as the shot count gives, fewer if the buffer empties first.
// - One-shot resends the last sent image from the retransmit store.
// - With the source select at 0, one-shot acts as single-frame and multi-shot as multi-frame capture.
// - While the buffer is on, every captured image enters the ring buffer, except in a cycle that empties it.
// - A capture into a full ring buffer overwrites the oldest image.
// - Every transmitted image is copied into the retransmit store.
// - One-shot still sends the retransmit store when it holds nothing valid.
// - Writing 1 to the buffer-on bit empties the ring buffer.
// - A new image configuration empties the buffer and renews the capacity.
// - Control bit 31 turns the ring buffer off (0) or on (1).
// - Control bit 30 picks live (0) or buffered (1) data, kept while streaming.
// - Bits 12 to 23 read back the nonzero buffer capacity.
// - Bits 0 to 11 read back how many images are stored.
package ifb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IMG_W = 16;
  localparam int CFG_W = 16;
  localparam int CNT_W = 12;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h634;
  localparam int BIT_BUF_ON = 31;
  localparam int BIT_SEL = 30;
  localparam int RSV_W = 6;
  localparam logic [RSV_W-1:0] RSV_ZERO = 6'h00;
  localparam int CAP_LSB = 12;
  localparam int CAP_MSB = 23;
  localparam int CNT_LSB = 0;
  localparam int CNT_MSB = 11;
  localparam int COLOR_LSB = 0;
  localparam int COLOR_MSB = 1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CAP_RST = 12'h008;
  localparam logic [CNT_W-1:0] CAP_C0 = 12'h008;
  localparam logic [CNT_W-1:0] CAP_C1 = 12'h004;
  localparam logic [CNT_W-1:0] CAP_C2 = 12'h002;
  localparam logic [CNT_W-1:0] CAP_C3 = 12'h001;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
  localparam logic [IMG_W-1:0] IMG_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LIVE,
    ST_ONE,
    ST_BUFM
  } ifb_state_t;

  function automatic logic [CNT_W-1:0] cap_lookup(
    input logic [COLOR_MSB:COLOR_LSB] color
  );
    case (color)
      2'h0: cap_lookup = CAP_C0;
      2'h1: cap_lookup = CAP_C1;
      2'h2: cap_lookup = CAP_C2;
      default: cap_lookup = CAP_C3;
    endcase
  endfunction : cap_lookup
endpackage : ifb_pkg

// file: verif/ifb_top_tb.sv
// Self-checking bench for the image frame buffer control block.
module ifb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [ifb_pkg::ADDR_W-1:0] CTRL = ifb_pkg::REG_CTRL;
  logic sys_clk, sys_rst, reg_wr, reg_rd, cap_valid;
  logic acq_continuous, stream_en, one_shot, multi_shot;
  logic [ifb_pkg::ADDR_W-1:0] reg_addr;
  logic [ifb_pkg::DATA_W-1:0] reg_wdata, reg_rdata, rv;
  logic [ifb_pkg::CFG_W-1:0] img_cfg;
  logic [ifb_pkg::IMG_W-1:0] cap_data, tx_data;
  logic [ifb_pkg::CNT_W-1:0] shot_count;
  logic tx_valid, tx_buffered;
  logic [17:0] tx_seen;
  int fail_count = 0;
  int check_count = 0;

  ifb_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .img_cfg(img_cfg), .cap_valid(cap_valid),
    .cap_data(cap_data), .acq_continuous(acq_continuous),
    .stream_en(stream_en), .one_shot(one_shot), .multi_shot(multi_shot),
    .shot_count(shot_count), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_buffered(tx_buffered));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  task automatic cap(input logic [15:0] d);
    @(posedge sys_clk);
    cap_valid <= 1'b1;
    cap_data <= d;
    @(posedge sys_clk);
    cap_valid <= 1'b0;
  endtask : cap

  task automatic shot(input logic one, input logic multi,
                      input logic [11:0] n);
    @(posedge sys_clk);
    one_shot <= one;
    multi_shot <= multi;
    shot_count <= n;
    @(posedge sys_clk);
    one_shot <= 1'b0;
    multi_shot <= 1'b0;
  endtask : shot

  // Valid, data and source of the first image within six cycles
  task automatic wait_tx();
    tx_seen = 18'h00000;
    for (int i = 0; i < 6; i++) begin
      #1;
      if (tx_valid === 1'b1) begin
        tx_seen = {1'b1, tx_data, tx_buffered};
        break;
      end
      @(posedge sys_clk);
    end
  endtask : wait_tx

  task automatic t_reset_values();
    rd(CTRL);
    chk("ctrl reset", rv, 32'h0000_8000);
    rd(12'h630);
    chk("unmapped", rv, 32'h0000_0000);
    wr(CTRL, 32'h4000_0000);
    shot(1'b1, 1'b0, 12'h000);
    wait_tx();
    chk("empty resend", 32'(tx_seen), {15'h0001, 16'h0000, 1'b1});
  endtask : t_reset_values

  task automatic t_buffer_fill();
    wr(CTRL, 32'hc000_0000);
    cap(16'h00a1);
    cap(16'h00a2);
    cap(16'h00a3);
    rd(CTRL);
    chk("count three", rv, 32'hc000_8003);
    wr(CTRL, 32'hc000_0000);
    rd(CTRL);
    chk("buffer init", rv, 32'hc000_8000);
  endtask : t_buffer_fill

  task automatic t_overwrite_multi();
    @(posedge sys_clk);
    img_cfg <= 16'h0003;
    rd(CTRL);
    chk("cfg change", rv, 32'hc000_1000);
    cap(16'h00b1);
    cap(16'h00b2);
    rd(CTRL);
    chk("full count", rv, 32'hc000_1001);
    shot(1'b0, 1'b1, 12'h001);
    wait_tx();
    chk("multi tx", 32'(tx_seen), {15'h0001, 16'h00b2, 1'b1});
    rd(CTRL);
    chk("after pop", rv, 32'hc000_1000);
    shot(1'b1, 1'b0, 12'h000);
    wait_tx();
    chk("one tx", 32'(tx_seen), {14'h0, 1'b1, 16'h00b2, 1'b1});
  endtask : t_overwrite_multi

  task automatic t_continuous();
    @(posedge sys_clk);
    acq_continuous <= 1'b1;
    shot(1'b1, 1'b0, 12'h000);
    wait_tx();
    chk("no buffered tx", 32'(tx_seen), 32'h0000_0000);
    cap(16'h00c1);
    wait_tx();
    chk("live tx", 32'(tx_seen), {14'h0, 1'b1, 16'h00c1, 1'b0});
    @(posedge sys_clk);
    acq_continuous <= 1'b0;
    shot(1'b1, 1'b0, 12'h000);
    wait_tx();
    chk("resend live", 32'(tx_seen), {14'h0, 1'b1, 16'h00c1, 1'b1});
  endtask : t_continuous

  task automatic t_select_live();
    @(posedge sys_clk);
    stream_en <= 1'b1;
    wr(CTRL, 32'h8000_0000);
    rd(CTRL);
    chk("select held", rv, 32'hc000_1000);
    @(posedge sys_clk);
    stream_en <= 1'b0;
    wr(CTRL, 32'h8000_0000);
    rd(CTRL);
    chk("select clear", rv, 32'h8000_1000);
    shot(1'b0, 1'b1, 12'h002);
    cap(16'h00d1);
    wait_tx();
    chk("live first", 32'(tx_seen), {14'h0, 1'b1, 16'h00d1, 1'b0});
    cap(16'h00d2);
    wait_tx();
    chk("live second", 32'(tx_seen), {14'h0, 1'b1, 16'h00d2, 1'b0});
    cap(16'h00d3);
    wait_tx();
    chk("live done", 32'(tx_seen), 32'h0000_0000);
  endtask : t_select_live

  task automatic t_ring_wrap();
    @(posedge sys_clk);
    img_cfg <= 16'h0001;
    rd(CTRL);
    chk("cap four", rv, 32'h8000_4000);
    @(posedge sys_clk);
    img_cfg <= 16'h0002;
    wr(CTRL, 32'hc000_0000);
    cap(16'h00e1);
    cap(16'h00e2);
    cap(16'h00e3);
    rd(CTRL);
    chk("wrap count", rv, 32'hc000_2002);
    shot(1'b0, 1'b1, 12'h003);
    wait_tx();
    chk("wrap first", 32'(tx_seen), {15'h0001, 16'h00e2, 1'b1});
    @(posedge sys_clk);
    #1;
    tx_seen = {tx_valid, tx_data, tx_buffered};
    chk("wrap second", 32'(tx_seen), {15'h0001, 16'h00e3, 1'b1});
    @(posedge sys_clk);
    #1;
    chk("wrap stop", 32'(tx_valid), 32'h0000_0000);
    rd(CTRL);
    chk("wrap empty", rv, 32'hc000_2000);
  endtask : t_ring_wrap

  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, cap_valid, acq_continuous} = 4'h0;
    {stream_en, one_shot, multi_shot} = 3'h0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    img_cfg = 16'h0000;
    cap_data = 16'h0000;
    shot_count = 12'h000;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_buffer_fill();
    t_overwrite_multi();
    t_continuous();
    t_select_live();
    t_ring_wrap();
    close_out();
  end
endmodule : ifb_top_tb
